/* hdl/gate_drive_consts.vh */
// constants for the gate drive lockout and serial command logic
// assumes one 20 MHz clock and no register bus
//
// How it works
// - standby or fault forces gates low, locks high side
// - both enables high enable low side, leave standby
// - all high-side asserted, low sides off, turns every live high gate on
// - edge inputs; high side re-engaged after low toggle
// - tied or separate phase inputs give same result
// - reset release with enables low powers up
// - mask command upper nibble 0010 or 0011
// - mode command with lock bit blocks later changes
// - high input one is off, low input one is on
// - reply to a command comes in the next frame
`ifndef GATE_DRIVE_CONSTS_VH
`define GATE_DRIVE_CONSTS_VH

// ***************************************************
// timing
// ***************************************************
`define CLK_PERIOD_NS      50
`define MIN_LOW_PULSE_NS   100
`define MIN_LOW_PULSE_CYC  ((`MIN_LOW_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ENABLE_SETTLE_NS   280
`define ENABLE_SETTLE_CYC  ((`ENABLE_SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// ***************************************************
// serial commands (8-bit frames, msb first)
// ***************************************************
`define CMD_WIDTH          8
`define CMD_MASK_NIB_A     4'h2
`define CMD_MASK_NIB_B     4'h3
`define CMD_MODE_NIB       4'h4
`define CMD_DEAD_NIB       4'h8
`define CMD_QUERY_ZERO     8'h00
`define CMD_QUERY_ONE      8'h01
`define CMD_CLEAR_ZERO     8'h6c
`define CMD_CLEAR_ONE      8'h6d
`define MODE_LOCK_BIT      0
`define MASK_RESET         5'h00
`define MODE_RESET         3'h0
`define DEAD_RESET         4'h0

`endif

/* hdl/gate_drive_init_lockout.v */
// gate pre-driver control: standby, lockout, re-init, serial setup
// assumes all pins asynchronous; single 20 MHz clock CLK
// assumes CE stays high except where the whole block must freeze
`timescale 1ns/1ps
`default_nettype none
`include "gate_drive_consts.vh"

module gate_drive_init_lockout (
	input  wire       CLK,
	input  wire       RST_N,
	input  wire       CE,
	input  wire [2:0] LOW_SIDE_IN,      // phase c,b,a low-side inputs
	input  wire [2:0] HIGH_SIDE_IN_N,   // phase c,b,a high-side inputs
	input  wire       ENABLE_PIN_FIRST,
	input  wire       ENABLE_PIN_SECOND,
	input  wire       FAULT_IN,         // fault shutdown request
	input  wire       SCLK,
	input  wire       CS_N,
	input  wire       MOSI,
	output wire       MISO,
	output reg  [2:0] HIGH_GATE_OUT,    // high-side gate on
	output reg  [2:0] LOW_GATE_OUT,     // low-side gate on
	output reg  [2:0] HIGH_SOURCE_TIE,  // gate tied to source, off
	output reg  [2:0] HIGH_LOCKED,      // per-phase lockout state
	output reg        STANDBY_STATE,
	output reg        IRQ_N,            // interrupt, low active
	output reg  [3:0] DEAD_TIME,
	output reg  [2:0] MODE_BITS,
	output reg        MODE_LOCKED
);
	// ***************************************************
	// state codes
	// ***************************************************
	localparam ST_STANDBY = 2'd0;   // outputs low, enables low
	localparam ST_SETTLE  = 2'd1;   // waiting out enable delay
	localparam ST_NORMAL  = 2'd2;   // drivers follow inputs
	// code three never occurs; it falls back to standby

	// per-phase high-side lockout codes
	localparam HS_LOCKED = 2'd0;   // no input control
	localparam HS_ARMED  = 2'd1;   // low side toggled, waiting edge
	localparam HS_LIVE   = 2'd2;   // re-engaged
	// code three is unused and is driven as live by the default branch

	// settle count is a small constant; cut to the counter's width on purpose
	localparam integer SETTLE_INT = `ENABLE_SETTLE_CYC;
	localparam [3:0]   SETTLE_CYC = SETTLE_INT[3:0];

	// ***************************************************
	// pin synchronisers
	// ***************************************************
	wire [2:0] ls_s;    // synchronised low-side levels
	wire [2:0] hs_s;    // synchronised high-side levels
	wire       en1_s;
	wire       en2_s;
	wire       flt_s;
	wire       sclk_s;
	wire       cs_s;
	wire       mosi_s;

	// every pin passes three flops; a change shows four edges later,
	// which the host must allow for in its pulse widths
	genvar g;
	generate
		for (g = 0; g < 3; g = g + 1) begin : g_ph_sync
			pin_sync #(.RESET_VAL(1'b0)) u_ls (
				.clk(CLK), .rst_n(RST_N), .ce(CE),
				.pin(LOW_SIDE_IN[g]), .level(ls_s[g]));
			pin_sync #(.RESET_VAL(1'b1)) u_hs (
				.clk(CLK), .rst_n(RST_N), .ce(CE),
				.pin(HIGH_SIDE_IN_N[g]), .level(hs_s[g]));
		end
	endgenerate

	// enables and fault share the same filter, so a glitch shorter
	// than one clock never reaches the state machine
	pin_sync #(.RESET_VAL(1'b0)) u_en1 (.clk(CLK), .rst_n(RST_N), .ce(CE),
		.pin(ENABLE_PIN_FIRST), .level(en1_s));
	pin_sync #(.RESET_VAL(1'b0)) u_en2 (.clk(CLK), .rst_n(RST_N), .ce(CE),
		.pin(ENABLE_PIN_SECOND), .level(en2_s));
	pin_sync #(.RESET_VAL(1'b0)) u_flt (.clk(CLK), .rst_n(RST_N), .ce(CE),
		.pin(FAULT_IN), .level(flt_s));
	// serial lines idle with clock low and select high
	pin_sync #(.RESET_VAL(1'b0)) u_sck (.clk(CLK), .rst_n(RST_N), .ce(CE),
		.pin(SCLK), .level(sclk_s));
	pin_sync #(.RESET_VAL(1'b1)) u_cs (.clk(CLK), .rst_n(RST_N), .ce(CE),
		.pin(CS_N), .level(cs_s));
	pin_sync #(.RESET_VAL(1'b0)) u_mosi (.clk(CLK), .rst_n(RST_N), .ce(CE),
		.pin(MOSI), .level(mosi_s));

	// ***************************************************
	// serial command port
	// ***************************************************
	wire       cmd_valid;   // one-cycle command pulse
	wire [7:0] cmd_word;    // decoded frame
	reg  [7:0] reply_next;  // reply chosen for this command
	reg  [4:0] mask_reg;    // interrupt source mask
	reg  [1:0] flags_reg;   // sticky status: fault, standby entry

	// the port sees only filtered levels, so each serial clock half
	// period must last at least two CLK cycles
	serial_cmd u_ser (
		.clk       (CLK),
		.rst_n     (RST_N),
		.ce        (CE),
		.sclk      (sclk_s),
		.cs_n      (cs_s),
		.mosi      (mosi_s),
		.reply_word(reply_next),
		.miso      (MISO),
		.cmd_valid (cmd_valid),
		.cmd_word  (cmd_word)
	);

	// reply content: status queries answer state, others echo
	// the reply shows state before the command's own effect lands
	always @* begin
		if (cmd_word == `CMD_QUERY_ZERO) begin
			reply_next = {4'h0, STANDBY_STATE, MODE_LOCKED, flags_reg};
		end else if (cmd_word == `CMD_QUERY_ONE) begin
			reply_next = {1'b0, HIGH_LOCKED != 3'b000, 1'b0, mask_reg};
		end else begin
			reply_next = cmd_word;
		end
	end

	// decode runs on the held word; only meaningful while cmd_valid pulses
	wire is_mask  = (cmd_word[7:4] == `CMD_MASK_NIB_A) ||
	                (cmd_word[7:4] == `CMD_MASK_NIB_B);
	wire is_mode  = (cmd_word[7:4] == `CMD_MODE_NIB);
	wire is_dead  = (cmd_word[7:4] == `CMD_DEAD_NIB);
	wire is_clr   = (cmd_word == `CMD_CLEAR_ZERO) || (cmd_word == `CMD_CLEAR_ONE);

	// ***************************************************
	// configuration and status flags
	// ***************************************************
	reg [1:0] st_reg;         // main state
	reg [1:0] st_next;
	reg       fault_d_reg;    // fault edge detect

	// flag bit one: fault rise; bit zero: enable drop out of settle or normal
	wire fault_rise   = flt_s & ~fault_d_reg;
	wire standby_state_enter   = (st_reg != ST_STANDBY) && (!en1_s || !en2_s);
	wire [1:0] evt    = {fault_rise, standby_state_enter};

	// set wins over a clear in the same cycle
	always @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			mask_reg    <= `MASK_RESET;
			MODE_BITS   <= `MODE_RESET;
			MODE_LOCKED <= 1'b0;
			DEAD_TIME   <= `DEAD_RESET;
			flags_reg   <= 2'b00;
			fault_d_reg <= 1'b0;
			IRQ_N       <= 1'b1;
		end else if (CE) begin
			fault_d_reg <= flt_s;
			if (cmd_valid && is_mask) begin
				mask_reg <= cmd_word[4:0];
			end
			// locked mode rejects further changes
			if (cmd_valid && is_mode && !MODE_LOCKED) begin
				MODE_BITS   <= cmd_word[3:1];
				MODE_LOCKED <= cmd_word[`MODE_LOCK_BIT];
			end
			if (cmd_valid && is_dead) begin
				DEAD_TIME <= cmd_word[3:0];
			end
			if (cmd_valid && is_clr) begin
				flags_reg <= evt;
			end else begin
				flags_reg <= flags_reg | evt;
			end
			// irq trails the flags by a cycle; only two mask bits gate it
			IRQ_N <= ~|(flags_reg & ~mask_reg[1:0]);
		end
	end

	// ***************************************************
	// standby / normal state machine
	// ***************************************************
	reg [3:0] settle_reg;   // enable settling count

	always @* begin
		st_next = st_reg;
		// a fault or an enable drop wins over the settle count
		case (st_reg)
			ST_STANDBY: begin
				if (en1_s && en2_s && !flt_s) begin
					st_next = ST_SETTLE;
				end
			end
			ST_SETTLE: begin
				if (!en1_s || !en2_s || flt_s) begin
					st_next = ST_STANDBY;
				end else if (settle_reg == SETTLE_CYC) begin
					st_next = ST_NORMAL;
				end
			end
			ST_NORMAL: begin
				if (!en1_s || !en2_s || flt_s) begin
					st_next = ST_STANDBY;
				end
			end
			default: begin
				st_next = ST_STANDBY;
			end
		endcase
	end

	// state register and settle counter
	// standby output follows the registered state, so it moves on the
	// same edge as the gate forcing in the phase logic below
	always @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			st_reg        <= ST_STANDBY;
			settle_reg    <= 4'h0;
			STANDBY_STATE <= 1'b1;
		end else if (CE) begin
			st_reg        <= st_next;
			STANDBY_STATE <= (st_reg != ST_NORMAL);   // with gate forcing
			// counter restarts whenever settle is left, so a bounced
			// enable waits the full delay again
			if (st_reg == ST_SETTLE) begin
				settle_reg <= settle_reg + 4'h1;
			end else begin
				settle_reg <= 4'h0;
			end
		end
	end

	// ***************************************************
	// per-phase lockout and gate drive
	// ***************************************************
	// edge detectors reset to idle pin levels, so no false edge follows reset
	reg [2:0] ls_d_reg;   // previous low-side levels
	reg [2:0] hs_d_reg;   // previous high-side levels
	reg [1:0] hs_st_reg [0:2];

	// drivers act only in normal mode; settle keeps them forced off
	wire normal = (st_reg == ST_NORMAL);

	// tied inputs rise and fall together: the low-side rise arms in the
	// same cycle, and the matching high-side fall is judged afterwards
	generate
		for (g = 0; g < 3; g = g + 1) begin : g_phase
			wire ls_rise = ls_s[g] & ~ls_d_reg[g];
			wire ls_fall = ~ls_s[g] & ls_d_reg[g];
			wire hs_fall = ~hs_s[g] & hs_d_reg[g];
			always @(posedge CLK or negedge RST_N) begin
				if (!RST_N) begin
					ls_d_reg[g]        <= 1'b0;
					hs_d_reg[g]        <= 1'b1;
					hs_st_reg[g]       <= HS_LOCKED;
					HIGH_GATE_OUT[g]   <= 1'b0;
					LOW_GATE_OUT[g]    <= 1'b0;
					HIGH_SOURCE_TIE[g] <= 1'b0;
					HIGH_LOCKED[g]     <= 1'b1;
				end else if (CE) begin
					ls_d_reg[g] <= ls_s[g];
					hs_d_reg[g] <= hs_s[g];
					// leaving normal drops every phase back to locked
					if (!normal) begin   // force low and lock
						hs_st_reg[g]       <= HS_LOCKED;
						HIGH_GATE_OUT[g]   <= 1'b0;
						LOW_GATE_OUT[g]    <= 1'b0;
						HIGH_SOURCE_TIE[g] <= 1'b0;
						HIGH_LOCKED[g]     <= 1'b1;
					end else begin
						// low side follows level; one is on
						// a live high side that is on blocks its low side
						LOW_GATE_OUT[g] <= ls_s[g] & (hs_st_reg[g] != HS_LIVE | hs_s[g]);
						case (hs_st_reg[g])
							HS_LOCKED: begin
								// only this phase's own low rise arms
								if (ls_rise) begin
									hs_st_reg[g] <= HS_ARMED;
								end
								HIGH_GATE_OUT[g] <= 1'b0;
							end
							HS_ARMED: begin
								// high edge after low toggle re-engages
								if (hs_fall || (ls_fall && !hs_s[g])) begin
									hs_st_reg[g]   <= HS_LIVE;
									HIGH_LOCKED[g] <= 1'b0;
								end
								HIGH_GATE_OUT[g] <= 1'b0;
							end
							default: begin
								// zero means on, one means off
								HIGH_GATE_OUT[g]   <= ~hs_s[g] & ~ls_s[g];
								// off gate held to source
								HIGH_SOURCE_TIE[g] <= hs_s[g];
							end
						endcase
					end
				end
			end
		end
	endgenerate
endmodule

`default_nettype wire

/* hdl/pin_sync.v */
// three-flop synchroniser with agreement filter for one pin
// assumes the pin is asynchronous to CLK
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
	parameter RESET_VAL = 1'b0   // level shown after reset
) (
	input  wire clk,
	input  wire rst_n,
	input  wire ce,
	input  wire pin,
	output reg  level
);
	// ***************************************************
	// sync chain
	// ***************************************************
	reg s1_reg;   // metastable stage, read only by s2
	reg s2_reg;   // second stage
	reg s3_reg;   // third stage

	// change counts only once stages two and three agree
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s1_reg <= RESET_VAL;
			s2_reg <= RESET_VAL;
			s3_reg <= RESET_VAL;
			level  <= RESET_VAL;
		end else if (ce) begin
			s1_reg <= pin;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			if (s2_reg == s3_reg) begin   // agreed
				level <= s3_reg;
			end
		end
	end
endmodule

`default_nettype wire

/* hdl/serial_cmd.v */
// serial command port: 8-bit frames, reply shifted out in next frame
// assumes sclk and cs_n are already synchronised levels from pin_sync
`timescale 1ns/1ps
`default_nettype none
`include "gate_drive_consts.vh"

module serial_cmd (
	input  wire       clk,
	input  wire       rst_n,
	input  wire       ce,
	input  wire       sclk,        // synchronised serial clock
	input  wire       cs_n,        // synchronised frame select, low active
	input  wire       mosi,        // synchronised data in
	input  wire [7:0] reply_word,  // reply for the command just taken
	output reg        miso,        // data out, from flop
	output reg        cmd_valid,   // one-cycle pulse at frame end
	output reg  [7:0] cmd_word     // last full command
);
	// ***************************************************
	// frame state
	// ***************************************************
	reg       sclk_d_reg;   // previous serial clock
	reg       cs_d_reg;     // previous frame select
	reg [7:0] rx_reg;       // incoming shift
	reg [7:0] tx_reg;       // outgoing shift
	reg [7:0] pend_reg;     // reply held for the next frame
	reg [3:0] cnt_reg;      // bits in this frame

	wire rise  = sclk & ~sclk_d_reg;
	wire fall  = ~sclk & sclk_d_reg;
	wire start = ~cs_n & cs_d_reg;
	wire stop  = cs_n & ~cs_d_reg;

	// shift in on rise, out on fall; reply loads at frame start
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sclk_d_reg <= 1'b0;
			cs_d_reg   <= 1'b1;
			rx_reg     <= 8'h00;
			tx_reg     <= 8'h00;
			pend_reg   <= 8'h00;
			cnt_reg    <= 4'h0;
			miso       <= 1'b0;
			cmd_valid  <= 1'b0;
			cmd_word   <= 8'h00;
		end else if (ce) begin
			sclk_d_reg <= sclk;
			cs_d_reg   <= cs_n;
			cmd_valid  <= 1'b0;
			if (start) begin   // previous reply goes out now
				tx_reg  <= {pend_reg[6:0], 1'b0};
				miso    <= pend_reg[7];
				cnt_reg <= 4'h0;
			end else if (stop) begin
				// short frames are dropped, not half-decoded
				if (cnt_reg == 4'h8) begin
					cmd_valid <= 1'b1;
					cmd_word  <= rx_reg;
				end
			end else if (!cs_n) begin
				if (rise) begin
					rx_reg <= {rx_reg[6:0], mosi};
					if (cnt_reg != 4'hf) begin
						cnt_reg <= cnt_reg + 4'h1;
					end
				end else if (fall) begin
					miso   <= tx_reg[7];
					tx_reg <= {tx_reg[6:0], 1'b0};
				end
			end
			// reply is captured the cycle after the command decodes
			if (cmd_valid) begin
				pend_reg <= reply_word;   // held for next frame
			end
		end
	end
endmodule

`default_nettype wire

/* test/gate_drive_checks_properties.sv */
// concurrent checks on the gate drive lockout ports
// assumes a bind from the bench top; one clock, async low reset
`timescale 1ns/1ps
`default_nettype none
module gate_drive_checks (
	input wire logic       CLK,
	input wire logic       RST_N,
	input wire logic       CE,
	input wire logic [2:0] HIGH_SIDE_IN_N,
	input wire logic       ENABLE_PIN_FIRST,
	input wire logic       ENABLE_PIN_SECOND,
	input wire logic       FAULT_IN,
	input wire logic       CS_N,
	input wire logic       MISO,
	input wire logic [2:0] HIGH_GATE_OUT,
	input wire logic [2:0] LOW_GATE_OUT,
	input wire logic [2:0] HIGH_SOURCE_TIE,
	input wire logic [2:0] HIGH_LOCKED,
	input wire logic       STANDBY_STATE,
	input wire logic [2:0] MODE_BITS,
	input wire logic       MODE_LOCKED
);
	// ****
	// properties
	// ****
	// run request: both enables up, no fault
	wire logic go = ENABLE_PIN_FIRST & ENABLE_PIN_SECOND & ~FAULT_IN;
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RST_N || !CE);
	property p_off; STANDBY_STATE |-> HIGH_GATE_OUT == 3'h0 && LOW_GATE_OUT == 3'h0; endproperty
	a_off: assert property (p_off) else $error("gate on in standby");
	property p_lock; STANDBY_STATE |-> HIGH_LOCKED == 3'h7; endproperty
	a_lock: assert property (p_lock) else $error("high side free in standby");
	// sync plus settle is short, so 17 steady cycles must reach normal
	property p_run; $rose(go) ##1 go [*8] ##1 go [*8] |-> !STANDBY_STATE; endproperty
	a_run: assert property (p_run) else $error("no exit from standby");
	property p_stop; $fell(go) |-> ##[1:8] STANDBY_STATE && HIGH_LOCKED == 3'h7; endproperty
	a_stop: assert property (p_stop) else $error("no shutdown");
	property p_idle; !ENABLE_PIN_FIRST [*8] |-> STANDBY_STATE; endproperty
	a_idle: assert property (p_idle) else $error("left standby unenabled");
	// never two gates of a phase, never a locked or tied gate on
	property p_excl;
		(HIGH_GATE_OUT & (LOW_GATE_OUT | HIGH_LOCKED | HIGH_SOURCE_TIE)) == 3'h0;
	endproperty
	a_excl: assert property (p_excl) else $error("gate overlap");
	// a phase unlocks only with its own high input held low
	property p_free;
		(~HIGH_LOCKED & $past(HIGH_LOCKED) & $past(HIGH_SIDE_IN_N, 2)) == 3'h0;
	endproperty
	a_free: assert property (p_free) else $error("unlock without edge");
	property p_mode; MODE_LOCKED |=> MODE_LOCKED && $stable(MODE_BITS); endproperty
	a_mode: assert property (p_mode) else $error("mode moved when locked");
	property p_miso; CS_N [*8] |=> $stable(MISO); endproperty
	a_miso: assert property (p_miso) else $error("reply moved between frames");
	// frozen block: gates, locks, standby and MISO hold while CE is low
	property p_hold;
		@(posedge CLK) disable iff (!RST_N)
		!CE |=> $stable({HIGH_GATE_OUT, LOW_GATE_OUT, HIGH_LOCKED, STANDBY_STATE, MISO});
	endproperty
	a_hold: assert property (p_hold) else $error("state moved while frozen");
	c_run: cover property ($fell(STANDBY_STATE));
	c_mode: cover property ($rose(MODE_LOCKED));
	c_free: cover property ($fell(HIGH_LOCKED[2]));
endmodule
`default_nettype wire

/* test/host_model.sv */
// host controller model: phase pins, enables, fault, serial frames
// assumes the bench calls its tasks; pins move on falling CLK only
`timescale 1ns/1ps
`default_nettype none
module host_model (
	input  wire logic       clk,
	input  wire logic       miso,
	output logic      [2:0] ls,        // low-side inputs, 1 = on
	output logic      [2:0] hs_n,      // high-side inputs, 0 = on
	output logic            en_first,
	output logic            en_second,
	output logic            fault,
	output logic            sclk,      // stands low outside frames
	output logic            cs_n,
	output logic            mosi,
	output logic      [7:0] rx_byte,   // reply of the previous command
	output logic            rx_strobe  // one cycle after each frame
);
	// ****
	// pins and tasks
	// ****
	// idle levels at time zero: high side off, enables low
	initial begin
		ls = 3'h0;
		hs_n = 3'h7;
		en_first = 1'b0;
		en_second = 1'b0;
		fault = 1'b0;
		sclk = 1'b0;
		cs_n = 1'b1;
		mosi = 1'b0;
		rx_byte = 8'h00;
		rx_strobe = 1'b0;
	end
	task tick(input integer n);
		integer i;
		begin
			for (i = 0; i < n; i = i + 1)
				@(negedge clk);
		end
	endtask
	// all phases change in one step, no motor current
	task drive(input logic [2:0] l, input logic [2:0] h, input integer n);
		begin
			ls = l;
			hs_n = h;
			tick(n);
		end
	endtask
	task pins(input logic e, input logic f);
		begin
			en_first = e;
			en_second = e;
			fault = f;
		end
	endtask
	// msb first, half periods of 6 cycles; reply bit read before rise
	task frame(input logic [7:0] cmd);
		integer i;
		begin
			cs_n = 1'b0;
			tick(6);
			for (i = 7; i >= 0; i = i - 1) begin
				mosi = cmd[i];
				tick(6);
				rx_byte[i] = miso;
				sclk = 1'b1;
				tick(6);
				sclk = 1'b0;
			end
			tick(6);
			cs_n = 1'b1;
			mosi = ~mosi; // released line must not look held
			rx_strobe = 1'b1;
			tick(1);
			rx_strobe = 1'b0;
			tick(8);
		end
	endtask
endmodule
`default_nettype wire

/* test/tb.sv */
// self-checking bench for the gate drive lockout block
// assumes host_model drives all pins but clock, reset and CE; checker is bound at the foot
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic       clk;
	logic       rst_n;
	logic [8:0] exp_q[$];  // care bit and expected reply
	logic [8:0] note_e;    // oldest note
	logic [7:0] r;         // random draw
	logic [4:0] m;         // mask under test
	integer     errors, total_checks, cyc, i;
	wire  [2:0] ls, hs_n, hg, lg, tie, lck, mode;
	wire  [3:0] dead;
	wire  [7:0] rx_byte;
	wire        en_first, en_second, fault, sclk, cs_n, mosi, miso;
	wire        standby, irq_n, mlock, rx_strobe;
	logic       ce;          // clock enable, bench driven
	host_model host_model_i (
		.clk(clk), .miso(miso), .ls(ls), .hs_n(hs_n), .en_first(en_first),
		.en_second(en_second), .fault(fault), .sclk(sclk), .cs_n(cs_n), .mosi(mosi),
		.rx_byte(rx_byte), .rx_strobe(rx_strobe)
	);
	// clock enable driven by the bench for the freeze check
	gate_drive_init_lockout gate_drive_init_lockout_i (
		.CLK(clk), .RST_N(rst_n), .CE(ce), .LOW_SIDE_IN(ls), .HIGH_SIDE_IN_N(hs_n),
		.ENABLE_PIN_FIRST(en_first), .ENABLE_PIN_SECOND(en_second), .FAULT_IN(fault),
		.SCLK(sclk), .CS_N(cs_n), .MOSI(mosi), .MISO(miso), .HIGH_GATE_OUT(hg),
		.LOW_GATE_OUT(lg), .HIGH_SOURCE_TIE(tie), .HIGH_LOCKED(lck), .STANDBY_STATE(standby),
		.IRQ_N(irq_n), .DEAD_TIME(dead), .MODE_BITS(mode), .MODE_LOCKED(mlock)
	);
	// ****
	// checks and drivers
	// ****
	task chk_port(input logic [11:0] got, input logic [11:0] exp);
		begin
			total_checks = total_checks + 1;
			if (got !== exp) begin
				errors = errors + 1;
				$display("CHECK FAILED %0t port %h want %h", $time, got, exp);
			end
		end
	endtask
	task chk_reply(input logic [7:0] got, input logic [7:0] exp);
		begin
			total_checks = total_checks + 1;
			if (got !== exp) begin
				errors = errors + 1;
				$display("CHECK FAILED %0t reply %h want %h", $time, got, exp);
			end
		end
	endtask
	// the note is what this frame returns, i.e. the previous command's reply
	task send(input logic [7:0] c, input logic care, input logic [7:0] e);
		begin
			exp_q.push_back({care, e});
			host_model_i.frame(c);
		end
	endtask
	task step(input logic [2:0] l, input logic [2:0] h, input integer n, input logic [8:0] e);
		begin
			host_model_i.drive(l, h, n);
			chk_port({lck, hg, lg, 3'h0}, {e, 3'h0});
		end
	endtask
	task wait_standby(input logic v);
		integer k;
		begin
			k = 0;
			while (standby !== v && k < 40) begin
				host_model_i.tick(1);
				k = k + 1;
			end
			chk_port({11'h0, standby}, {11'h0, v});
		end
	endtask
	task give_verdict;
		begin
			$display("checks %0d errors %0d", total_checks, errors);
			if (errors == 0 && total_checks > 0)
				$display("DONE - PASS");
			else
				$display("DONE - FAIL");
			$finish;
		end
	endtask
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	// reply monitor: oldest note against each gathered byte
	always @(posedge clk) begin
		if (rx_strobe === 1'b1) begin
			note_e = exp_q.pop_front();
			if (note_e[8])
				chk_reply(rx_byte, note_e[7:0]);
		end
	end
	// hang guard, far above the few thousand cycles needed
	always @(posedge clk) begin
		cyc = cyc + 1;
		if (cyc == 20000) begin
			errors = errors + 1;
			give_verdict;
		end
	end
	initial begin
		errors = 0;
		total_checks = 0;
		cyc = 0;
		ce = 1'b1;
		rst_n = 1'b0;
		repeat (8) @(negedge clk);
		rst_n = 1'b1;
		r = $urandom(32'h7af9);
		host_model_i.tick(4);
		chk_port({6'h0, hg, lg}, 12'h000);
		chk_port({8'h0, lck, standby}, 12'h00f);
		chk_port({4'h0, dead, mode, mlock}, 12'h000);
		send(8'h6c, 1'b0, 8'h00);
		send(8'h6d, 1'b0, 8'h00);
		send(8'h00, 1'b0, 8'h00);
		send(8'h01, 1'b1, 8'h08);
		// both mask nibbles, random mask bits
		for (i = 0; i < 2; i = i + 1) begin
			r = $urandom;
			m = {i[0], r[3:0]};
			send({3'h1, m}, i == 0, 8'h40);
			send(8'h01, 1'b0, 8'h00);
			send(8'h00, 1'b1, {3'h2, m});
		end
		send(8'h85, 1'b0, 8'h00);
		chk_port({8'h0, dead}, 12'h005);
		send(8'h80, 1'b0, 8'h00);
		chk_port({8'h0, dead}, 12'h000);
		send(8'h4a, 1'b0, 8'h00);
		chk_port({8'h0, mode, mlock}, 12'h00a);
		send(8'h43, 1'b0, 8'h00);
		chk_port({8'h0, mode, mlock}, 12'h003);
		send(8'h4c, 1'b0, 8'h00);
		chk_port({8'h0, mode, mlock}, 12'h003);
		host_model_i.pins(1'b1, 1'b0);
		wait_standby(1'b0);
		host_model_i.tick(6);
		step(3'h0, 3'h7, 8, 9'h1c0);
		step(3'h7, 3'h7, 20, 9'h1c7);
		step(3'h0, 3'h7, 6, 9'h1c0);
		step(3'h0, 3'h0, 10, 9'h038);
		step(3'h0, 3'h7, 8, 9'h000);
		chk_port({9'h0, tie}, 12'h007);
		step(3'h1, 3'h7, 8, 9'h001);
		step(3'h0, 3'h6, 8, 9'h008);
		step(3'h1, 3'h6, 8, 9'h000);
		step(3'h0, 3'h7, 8, 9'h000);
		host_model_i.pins(1'b1, 1'b1);
		host_model_i.tick(8);
		chk_port({lck, hg, lg, 2'h0, standby}, 12'he01);
		chk_port({11'h0, irq_n}, {11'h0, m[1]});
		host_model_i.pins(1'b0, 1'b0);
		send(8'h6c, 1'b0, 8'h00);
		send(8'h6d, 1'b0, 8'h00);
		host_model_i.pins(1'b1, 1'b0);
		wait_standby(1'b0);
		host_model_i.tick(6);
		// a in order, b high edge too early, c tied inputs
		step(3'h0, 3'h5, 6, 9'h1c0);
		step(3'h0, 3'h7, 6, 9'h1c0);
		step(3'h7, 3'h7, 8, 9'h1c7);
		step(3'h0, 3'h3, 6, 9'h0e0);
		step(3'h0, 3'h2, 6, 9'h0a8);
		step(3'h0, 3'h7, 6, 9'h080);
		host_model_i.pins(1'b0, 1'b0);
		host_model_i.tick(8);
		chk_port({lck, hg, lg, 2'h0, standby}, 12'he01);
		chk_port({11'h0, irq_n}, {11'h0, m[0]});
		send(8'h00, 1'b0, 8'h00);
		send(8'h01, 1'b1, 8'h0d);
		send(8'h6c, 1'b1, {3'h2, m});
		send(8'h6d, 1'b0, 8'h00);
		chk_port({11'h0, irq_n}, 12'h001);
		// freeze: enables rise while CE is low, nothing may move
		ce = 1'b0;
		host_model_i.pins(1'b1, 1'b0);
		host_model_i.tick(30);
		chk_port({8'h0, lck, standby}, 12'h00f);
		ce = 1'b1;
		wait_standby(1'b0);
		give_verdict;
	end
endmodule
bind gate_drive_init_lockout gate_drive_checks gate_drive_checks_i (
	.CLK(CLK), .RST_N(RST_N), .CE(CE), .HIGH_SIDE_IN_N(HIGH_SIDE_IN_N),
	.FAULT_IN(FAULT_IN),
	.ENABLE_PIN_FIRST(ENABLE_PIN_FIRST), .ENABLE_PIN_SECOND(ENABLE_PIN_SECOND),
	.CS_N(CS_N), .MISO(MISO), .HIGH_GATE_OUT(HIGH_GATE_OUT), .LOW_GATE_OUT(LOW_GATE_OUT),
	.HIGH_SOURCE_TIE(HIGH_SOURCE_TIE), .HIGH_LOCKED(HIGH_LOCKED),
	.STANDBY_STATE(STANDBY_STATE), .MODE_BITS(MODE_BITS), .MODE_LOCKED(MODE_LOCKED)
);
`default_nettype wire
